// ### board_defs.svh
// Constants for the board initialisation command interpreter
// Functional notes
// - Comms-enable command enables comms, acknowledges.
// - Reset command restores defaults, echoes reset code.
// - Clock mode command; mode zero after restart.
// - Bus-rate digits set four stream groups.
// - Rate digit 0/1/2; default 8.192 MHz.
// - Store up to fifteen digits per channel.
// - Number is calling on TE, called on NT.
// - Companding M is mu-law, A default.
// - Feed F off, N on, asterisk unchanged.
// - Sixteen feed args, or four plus four.
// - Option one set stops automatic identifier requests.
// - Option two picks identifier check reply form.
// - Option three skips called number check.
// - All system options default to zero.
// - Port type N, T, U or unchanged.
// - Termination letters E/D for two buses.
// - Base slot: hex stream and two-digit slot.
// - Protocol level 2, 3 or P; default 3.
// - Third base address register maps message memory.
// - Interrupt assignment readable at 3Ch.
// - Fixed vendor and device identification codes.
// - Flag 01h posts a message; reader clears it.
// - Strings are NUL-terminated, at most 32 bytes.
`ifndef BOARD_DEFS_SVH
`define BOARD_DEFS_SVH
`define MBOX_BYTES 32
`define CMD_MBOX_ADDR 13'h1fc0
`define REP_MBOX_ADDR 13'h1f80
`define CMD_FLAG_ADDR 13'h1ffc
`define REP_FLAG_ADDR 13'h1ffe
`define FLAG_SET 8'h01
`define FLAG_FREE 8'h00
`define PORTS_BIG 16
`define PORTS_SMALL 4
`define NUM_DIGITS 15
`define CH_NUL 8'h00
`define CH_0 8'h30
`define CH_9 8'h39
`define CH_A 8'h41
`define CH_F 8'h46
`define CH_STAR 8'h2a
`define CH_B 8'h42
`define CH_C 8'h43
`define CH_D 8'h44
`define CH_E 8'h45
`define CH_I 8'h49
`define CH_L 8'h4c
`define CH_M 8'h4d
`define CH_N 8'h4e
`define CH_P 8'h50
`define CH_R 8'h52
`define CH_S 8'h53
`define CH_T 8'h54
`define CH_U 8'h55
`define CH_X 8'h58
`define RATE_2M 2'h0
`define RATE_4M 2'h1
`define RATE_8M 2'h2
`define PTYPE_UNUSED 2'h0
`define PTYPE_NT 2'h1
`define PTYPE_TE 2'h2
`define PROTO_L2 2'h0
`define PROTO_L3 2'h1
`define PROTO_L3PP 2'h2
`define CLOCK_MODE_RST 4'h0
`define CFG_ID_OFF 8'h00
`define CFG_BAR2_OFF 8'h18
`define CFG_INT_OFF 8'h3c
`define BAR2_SIZE_MASK 32'hffffe000
`endif

// ### board_pkg.sv
// Types shared by the command interpreter and configuration space
package board_pkg;
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } host_req_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } cfg_req_t;
  typedef struct packed {
    logic comms_en;
    logic [3:0] clock_mode;
    logic [3:0] clock_sub;
    logic [3:0][1:0] rate;
    logic law_mu;
    logic [15:0] feed_one;
    logic [15:0] feed_two;
    logic [15:0][1:0] ptype;
    logic opt_no_tei;
    logic opt_tei_split;
    logic opt_no_num_check;
    logic term_h100;
    logic term_legacy;
    logic [3:0] base_stream;
    logic [7:0] base_slot;
    logic [15:0][1:0] proto;
  } board_cfg_t;
  typedef struct packed {
    logic [14:0][3:0] digits;
    logic [3:0] len;
    logic calling;
  } number_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_REPLY} parse_state_t;
endpackage : board_pkg

// ### cfg_space.sv
// Bus configuration header: identity, message memory base, interrupt line
`timescale 1ns/100ps
`default_nettype none
`include "board_defs.svh"
module cfg_space #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h0001  // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration access
  input wire board_pkg::cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata_r
);
  import board_pkg::*;
  logic [31:0] bar2_r;
  logic [7:0] int_line_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bar2_r <= 32'h0;
      int_line_r <= 8'h0;
    end else if (cfg_req.we) begin
      if (cfg_req.addr == `CFG_BAR2_OFF)
        bar2_r <= cfg_req.wdata & `BAR2_SIZE_MASK;
      if (cfg_req.addr == `CFG_INT_OFF)
        int_line_r <= cfg_req.wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata_r <= 32'h0;
    end else if (cfg_req.re) begin
      case (cfg_req.addr)
        `CFG_ID_OFF: cfg_rdata_r <= {DEVICE_ID, VENDOR_ID};
        `CFG_BAR2_OFF: cfg_rdata_r <= bar2_r;
        `CFG_INT_OFF: cfg_rdata_r <= {24'h0, int_line_r};
        default: cfg_rdata_r <= 32'h0;
      endcase
    end
  end
endmodule : cfg_space
`default_nettype wire

// ### cmd_parser.sv
// Mailbox command interpreter holding the board initialisation settings
`timescale 1ns/100ps
`default_nettype none
`include "board_defs.svh"
module cmd_parser (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Board variant strap, high on the four-port board
  input wire logic four_port,
  // Message memory access from the host side
  input wire board_pkg::host_req_t host_req,
  output logic [7:0] host_rdata_r,
  // Configuration space access
  input wire board_pkg::cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata_r,
  // Settings and stored number lookup
  output board_pkg::board_cfg_t board_cfg_r,
  input wire logic [4:0] num_sel,
  output board_pkg::number_t num_out_r
);
  import board_pkg::*;

  logic [7:0] cmd_buf [`MBOX_BYTES];
  logic [7:0] rep_buf [`MBOX_BYTES];
  logic [7:0] cmd_flag_r, rep_flag_r;
  logic [14:0][3:0] num_dig_r [32];
  logic [3:0] num_len_r [32];
  logic strap_meta_r, strap_sync_r, four_r;
  parse_state_t state_r;
  logic [7:0] rep_c0_r, rep_c1_r;
  logic [5:0] len;
  logic [4:0] nports;

  function automatic logic is_dig(input logic [7:0] c);
    return (c >= `CH_0) && (c <= `CH_9);
  endfunction : is_dig

  function automatic logic [3:0] hexval(input logic [7:0] c);
    logic [7:0] v;
    v = (c >= `CH_A) ? (c - `CH_A + 8'h0a) : (c - `CH_0);
    return v[3:0];
  endfunction : hexval

  // Only the comms-enable and reset commands are answered
  function automatic logic wants_reply(input logic [7:0] c0, input logic [7:0] c1, input logic [5:0] n);
    return (n == 6'd2) && ((c0 == `CH_I && c1 == `CH_N) || (c0 == `CH_R && c1 == `CH_A));
  endfunction : wants_reply

  cfg_space u_cfg (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cfg_req(cfg_req),
    .cfg_rdata_r(cfg_rdata_r)
  );

  // Strap comes off a pin, so it is synchronised before use
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_r <= 1'b0;
      strap_sync_r <= 1'b0;
      four_r <= 1'b0;
    end else begin
      strap_meta_r <= four_port;
      strap_sync_r <= strap_meta_r;
      four_r <= strap_sync_r;
    end
  end
  assign nports = four_r ? 5'(`PORTS_SMALL) : 5'(`PORTS_BIG);

  // Length up to the terminator; no terminator reads as 32, refused by every command but the clock command
  always_comb begin
    len = 6'(`MBOX_BYTES);
    for (int i = `MBOX_BYTES - 1; i >= 0; i--) begin
      if (cmd_buf[i] == `CH_NUL)
        len = 6'(i);
    end
  end

  // Host writes the command mailbox only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `MBOX_BYTES; i++)
        cmd_buf[i] <= `CH_NUL;
    end else if (host_req.we && (host_req.addr >= `CMD_MBOX_ADDR) &&
                 (host_req.addr < `CMD_MBOX_ADDR + 13'(`MBOX_BYTES))) begin
      cmd_buf[5'(host_req.addr - `CMD_MBOX_ADDR)] <= host_req.wdata;
    end
  end

  // Host posts by writing 01h; the device frees it after consuming
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_flag_r <= `FLAG_FREE;
    end else if (host_req.we && host_req.addr == `CMD_FLAG_ADDR) begin
      cmd_flag_r <= host_req.wdata;
    end else if ((state_r == ST_EXEC && !wants_reply(cmd_buf[0], cmd_buf[1], len)) ||
                 (state_r == ST_REPLY && rep_flag_r == `FLAG_FREE)) begin
      cmd_flag_r <= `FLAG_FREE;
    end
  end

  // Reply flag: device setting wins over a host clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rep_flag_r <= `FLAG_FREE;
    end else if (state_r == ST_REPLY && rep_flag_r == `FLAG_FREE) begin
      rep_flag_r <= `FLAG_SET;
    end else if (host_req.we && host_req.addr == `REP_FLAG_ADDR) begin
      rep_flag_r <= host_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `MBOX_BYTES; i++)
        rep_buf[i] <= `CH_NUL;
    end else if (state_r == ST_REPLY && rep_flag_r == `FLAG_FREE) begin
      rep_buf[0] <= rep_c0_r;
      rep_buf[1] <= rep_c1_r;
      rep_buf[2] <= `CH_NUL;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_rdata_r <= 8'h0;
    end else if (host_req.re) begin
      if (host_req.addr == `CMD_FLAG_ADDR)
        host_rdata_r <= cmd_flag_r;
      else if (host_req.addr == `REP_FLAG_ADDR)
        host_rdata_r <= rep_flag_r;
      else if (host_req.addr >= `CMD_MBOX_ADDR && host_req.addr < `CMD_MBOX_ADDR + 13'(`MBOX_BYTES))
        host_rdata_r <= cmd_buf[5'(host_req.addr - `CMD_MBOX_ADDR)];
      else if (host_req.addr >= `REP_MBOX_ADDR && host_req.addr < `REP_MBOX_ADDR + 13'(`MBOX_BYTES))
        host_rdata_r <= rep_buf[5'(host_req.addr - `REP_MBOX_ADDR)];
      else
        host_rdata_r <= 8'h0;
    end
  end

  // Sequencer: a posted command is executed in one cycle, then answered if it is comms-enable or reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      rep_c0_r <= `CH_NUL;
      rep_c1_r <= `CH_NUL;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_flag_r != `FLAG_FREE)
            state_r <= ST_EXEC;
        end
        ST_EXEC: begin
          if (cmd_buf[0] == `CH_I && cmd_buf[1] == `CH_N && len == 6'd2) begin
            rep_c0_r <= `CH_I;
            rep_c1_r <= `CH_A;
            state_r <= ST_REPLY;
          end else if (cmd_buf[0] == `CH_R && cmd_buf[1] == `CH_A && len == 6'd2) begin
            rep_c0_r <= `CH_R;
            rep_c1_r <= `CH_A;
            state_r <= ST_REPLY;
          end else begin
            rep_c0_r <= `CH_NUL;
            state_r <= ST_IDLE;
          end
        end
        ST_REPLY: begin
          if (rep_flag_r == `FLAG_FREE)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Settings; malformed commands are dropped, but per-port letters are checked one by one and SX digits and SD number digits not at all
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      board_cfg_r <= '0;
      board_cfg_r.clock_mode <= `CLOCK_MODE_RST;
      board_cfg_r.rate <= {4{`RATE_8M}};
      board_cfg_r.ptype <= {16{`PTYPE_UNUSED}};
      board_cfg_r.proto <= {16{`PROTO_L3}};
    end else if (state_r == ST_EXEC) begin
      if (cmd_buf[0] == `CH_I && cmd_buf[1] == `CH_N && len == 6'd2) begin
        board_cfg_r.comms_en <= 1'b1;
      end else if (cmd_buf[0] == `CH_R && cmd_buf[1] == `CH_A && len == 6'd2) begin
        board_cfg_r <= '0;
        board_cfg_r.clock_mode <= `CLOCK_MODE_RST;
        board_cfg_r.rate <= {4{`RATE_8M}};
        board_cfg_r.ptype <= {16{`PTYPE_UNUSED}};
        board_cfg_r.proto <= {16{`PROTO_L3}};
      end else if (cmd_buf[0] == `CH_S) begin
        case (cmd_buf[1])
          `CH_C: begin
            // Extra clock arguments are accepted and not interpreted here
            if (len >= 6'd4 && is_dig(cmd_buf[2]) && is_dig(cmd_buf[3])) begin
              board_cfg_r.clock_mode <= hexval(cmd_buf[2]);
              board_cfg_r.clock_sub <= hexval(cmd_buf[3]);
            end
          end
          `CH_B: begin
            if (len == 6'd6 && cmd_buf[2] <= `CH_0 + 8'd2 && cmd_buf[3] <= `CH_0 + 8'd2 &&
                cmd_buf[4] <= `CH_0 + 8'd2 && cmd_buf[5] <= `CH_0 + 8'd2 &&
                is_dig(cmd_buf[2]) && is_dig(cmd_buf[3]) && is_dig(cmd_buf[4]) && is_dig(cmd_buf[5])) begin
              for (int g = 0; g < 4; g++)
                board_cfg_r.rate[g] <= 2'(hexval(cmd_buf[2 + g]));
            end
          end
          `CH_E: begin
            if (len == 6'd3 && cmd_buf[2] == `CH_M)
              board_cfg_r.law_mu <= 1'b1;
            else if (len == 6'd3 && cmd_buf[2] == `CH_A)
              board_cfg_r.law_mu <= 1'b0;
          end
          `CH_F: begin
            if (len == 6'(nports) + 6'd2 + (four_r ? 6'd4 : 6'd0)) begin
              for (int p = 0; p < `PORTS_BIG; p++) begin
                if (p < 2 * `PORTS_SMALL || !four_r) begin
                  if (four_r && p >= `PORTS_SMALL) begin
                    if (cmd_buf[2 + p] == `CH_N)
                      board_cfg_r.feed_two[p - `PORTS_SMALL] <= 1'b1;
                    else if (cmd_buf[2 + p] == `CH_F)
                      board_cfg_r.feed_two[p - `PORTS_SMALL] <= 1'b0;
                  end else if (cmd_buf[2 + p] == `CH_N) begin
                    board_cfg_r.feed_one[p] <= 1'b1;
                  end else if (cmd_buf[2 + p] == `CH_F) begin
                    board_cfg_r.feed_one[p] <= 1'b0;
                  end
                end
              end
            end
          end
          `CH_S: begin
            if (len == 6'd5 && cmd_buf[2][7:1] == `CH_0 >> 1 &&
                cmd_buf[3][7:1] == `CH_0 >> 1 && cmd_buf[4][7:1] == `CH_0 >> 1) begin
              board_cfg_r.opt_no_tei <= cmd_buf[2][0];
              board_cfg_r.opt_tei_split <= cmd_buf[3][0];
              board_cfg_r.opt_no_num_check <= cmd_buf[4][0];
            end
          end
          `CH_T: begin
            if (len == 6'd4 && (cmd_buf[2] == `CH_E || cmd_buf[2] == `CH_D) &&
                (cmd_buf[3] == `CH_E || cmd_buf[3] == `CH_D)) begin
              board_cfg_r.term_h100 <= (cmd_buf[2] == `CH_E);
              board_cfg_r.term_legacy <= (cmd_buf[3] == `CH_E);
            end else if (len == 6'(nports) + 6'd2) begin
              for (int p = 0; p < `PORTS_BIG; p++) begin
                if (p < nports) begin
                  if (cmd_buf[2 + p] == `CH_N)
                    board_cfg_r.ptype[p] <= `PTYPE_NT;
                  else if (cmd_buf[2 + p] == `CH_T)
                    board_cfg_r.ptype[p] <= `PTYPE_TE;
                  else if (cmd_buf[2 + p] == `CH_U)
                    board_cfg_r.ptype[p] <= `PTYPE_UNUSED;
                end
              end
            end
          end
          `CH_X: begin
            if (len == 6'd5) begin
              board_cfg_r.base_stream <= hexval(cmd_buf[2]);
              board_cfg_r.base_slot <= {hexval(cmd_buf[3]), hexval(cmd_buf[4])};
            end
          end
          `CH_L: begin
            if (len == 6'(nports) + 6'd2) begin
              for (int p = 0; p < `PORTS_BIG; p++) begin
                if (p < nports) begin
                  if (cmd_buf[2 + p] == `CH_0 + 8'd2)
                    board_cfg_r.proto[p] <= `PROTO_L2;
                  else if (cmd_buf[2 + p] == `CH_0 + 8'd3)
                    board_cfg_r.proto[p] <= `PROTO_L3;
                  else if (cmd_buf[2 + p] == `CH_P)
                    board_cfg_r.proto[p] <= `PROTO_L3PP;
                end
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Subscriber numbers, two B channels per port
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < 32; c++) begin
        num_dig_r[c] <= '0;
        num_len_r[c] <= 4'h0;
      end
    end else if (state_r == ST_EXEC) begin
      if (cmd_buf[0] == `CH_R && cmd_buf[1] == `CH_A && len == 6'd2) begin
        for (int c = 0; c < 32; c++)
          num_len_r[c] <= 4'h0;
      end else if (cmd_buf[0] == `CH_S && cmd_buf[1] == `CH_D && len >= 6'd4 &&
                   len <= 6'd4 + 6'(`NUM_DIGITS) && is_dig(cmd_buf[2]) && is_dig(cmd_buf[3])) begin
        for (int c = 0; c < 32; c++) begin
          // Widen before the multiply so channels 16 and up do not wrap
          if (c < 2 * nports && 5'(c) == 5'(hexval(cmd_buf[2])) * 5'd10 + 5'(hexval(cmd_buf[3]))) begin
            num_len_r[c] <= 4'(len - 6'd4);
            for (int d = 0; d < `NUM_DIGITS; d++)
              num_dig_r[c][d] <= (6'(d) < len - 6'd4) ? hexval(cmd_buf[4 + d]) : 4'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      num_out_r <= '0;
    end else begin
      num_out_r.digits <= num_dig_r[num_sel];
      num_out_r.len <= num_len_r[num_sel];
      num_out_r.calling <= (board_cfg_r.ptype[num_sel[4:1]] == `PTYPE_TE);
    end
  end
endmodule : cmd_parser
`default_nettype wire

// ### cmd_parser_props.sv
// Concurrent checks on the command interpreter ports
`timescale 1ns/100ps
`default_nettype none
`include "board_defs.svh"
module cmd_parser_props #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h0001  // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Strap
  input wire logic four_port,
  // Message memory
  input wire board_pkg::host_req_t host_req,
  input wire logic [7:0] host_rdata_r,
  // Configuration space
  input wire board_pkg::cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata_r,
  // Settings and numbers
  input wire board_pkg::board_cfg_t board_cfg_r,
  input wire logic [4:0] num_sel,
  input wire board_pkg::number_t num_out_r
);
  import board_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] int_shadow_r;
  logic post_seen;
  // Shadow of the last interrupt line write, so reads can be tied to it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_shadow_r <= 8'h00;
    end else if (cfg_req.we && cfg_req.addr == `CFG_INT_OFF) begin
      int_shadow_r <= cfg_req.wdata[7:0];
    end
  end
  assign post_seen = host_req.we && host_req.addr == `CMD_FLAG_ADDR && host_req.wdata == `FLAG_SET;
  sequence id_read;
    cfg_req.re && cfg_req.addr == `CFG_ID_OFF;
  endsequence
  sequence win_read;
    cfg_req.re && cfg_req.addr == `CFG_BAR2_OFF;
  endsequence
  rst_defaults_a: assert property ($rose(reset_n) |-> board_cfg_r.clock_mode == 4'h0 && board_cfg_r.rate == 8'haa
    && !board_cfg_r.law_mu && board_cfg_r.proto == 32'h55555555 && !board_cfg_r.comms_en
    && {board_cfg_r.opt_no_tei, board_cfg_r.opt_tei_split, board_cfg_r.opt_no_num_check} == 3'h0)
    else $error("settings not at defaults after reset");
  id_fixed_a: assert property (id_read |=> cfg_rdata_r == {DEVICE_ID, VENDOR_ID})
    else $error("identity word wrong");
  win_size_a: assert property (win_read |=> cfg_rdata_r[12:0] == 13'h0000)
    else $error("message memory window not 8K aligned");
  int_line_a: assert property (cfg_req.re && cfg_req.addr == `CFG_INT_OFF |=> cfg_rdata_r[7:0] == int_shadow_r)
    else $error("interrupt line readback wrong");
  cmd_only_a: assert property (!$stable(board_cfg_r) |-> $past(post_seen, 2) || $past(post_seen, 3) || $past(post_seen, 4))
    else $error("settings changed without a posted command");
  codes_legal_a: assert property (board_cfg_r.proto != 32'hffffffff && board_cfg_r.rate[0] != 2'h3 && board_cfg_r.rate[3] != 2'h3)
    else $error("illegal rate or level code");
  flag_byte_a: assert property (host_req.re && host_req.addr == `REP_FLAG_ADDR |=> host_rdata_r inside {8'h00, 8'h01})
    else $error("reply flag holds odd value");
  unmapped_a: assert property (host_req.re && host_req.addr == 13'h0100 |=> host_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  num_role_a: assert property ($stable(num_sel) && $stable(board_cfg_r.ptype)
    |-> num_out_r.calling == (board_cfg_r.ptype[num_sel[4:1]] == `PTYPE_TE))
    else $error("number role does not follow port type");
endmodule : cmd_parser_props
bind cmd_parser cmd_parser_props u_props (.ref_clk(ref_clk), .reset_n(reset_n), .four_port(four_port),
  .host_req(host_req), .host_rdata_r(host_rdata_r), .cfg_req(cfg_req), .cfg_rdata_r(cfg_rdata_r),
  .board_cfg_r(board_cfg_r), .num_sel(num_sel), .num_out_r(num_out_r));
`default_nettype wire

// ### host_agent.sv
// Host driver model speaking the mailbox protocol
`timescale 1ns/100ps
`default_nettype none
`include "board_defs.svh"
module host_agent (
  // Clock
  input wire logic ref_clk,
  // Message memory port
  output var board_pkg::host_req_t host_req,
  input wire logic [7:0] host_rdata_r
);
  import board_pkg::*;
  initial host_req = '0;
  // Idle lines show the inverse of the last value so stale data is never mistaken for valid
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    host_req <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge ref_clk);
    host_req <= '{addr: ~a, wdata: ~v, we: 1'b0, re: 1'b0};
  endtask : wr
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    host_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge ref_clk);
    host_req <= '{addr: ~a, wdata: 8'hff, we: 1'b0, re: 1'b0};
    @(posedge ref_clk);
    v = host_rdata_r;
  endtask : rd
  // Whole string plus NUL, then the flag, then wait for the board to free it
  task automatic send(input string s);
    logic [7:0] f;
    int i;
    for (i = 0; i < s.len(); i++) wr(`CMD_MBOX_ADDR + 13'(i), s[i]);
    wr(`CMD_MBOX_ADDR + 13'(s.len()), `CH_NUL);
    wr(`CMD_FLAG_ADDR, `FLAG_SET);
    f = `FLAG_SET;
    for (i = 0; i < 60 && f !== `FLAG_FREE; i++) rd(`CMD_FLAG_ADDR, f);
  endtask : send
  task automatic reply(output string r);
    logic [7:0] c;
    int i;
    c = `FLAG_FREE;
    r = "";
    for (i = 0; i < 60 && c !== `FLAG_SET; i++) rd(`REP_FLAG_ADDR, c);
    for (i = 0; i < `MBOX_BYTES; i++) begin
      rd(`REP_MBOX_ADDR + 13'(i), c);
      if (c === `CH_NUL) break;
      r = {r, string'(c)};
    end
    wr(`REP_FLAG_ADDR, `FLAG_FREE);
  endtask : reply
endmodule : host_agent
`default_nettype wire

// ### cmd_parser_tb_top.sv
// Self-checking bench for the command interpreter
`timescale 1ns/100ps
`default_nettype none
`include "board_defs.svh"
module cmd_parser_tb_top;
  import board_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic four_port = 1'b0;
  host_req_t host_req;
  logic [7:0] host_rdata_r;
  cfg_req_t cfg_req = '0;
  logic [31:0] cfg_rdata_r;
  board_cfg_t board_cfg_r;
  logic [4:0] num_sel = 5'h00;
  number_t num_out_r;
  int mismatches = 0;
  int check_count = 0;
  string rep;
  logic [7:0] b;
  always #10 ref_clk = ~ref_clk;
  cmd_parser u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .four_port(four_port), .host_req(host_req),
    .host_rdata_r(host_rdata_r), .cfg_req(cfg_req), .cfg_rdata_r(cfg_rdata_r), .board_cfg_r(board_cfg_r),
    .num_sel(num_sel), .num_out_r(num_out_r));
  host_agent u_host (.ref_clk(ref_clk), .host_req(host_req), .host_rdata_r(host_rdata_r));
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic cmd(input string s);
    u_host.send(s);
    u_host.rd(`CMD_FLAG_ADDR, b);
    chk("cmd_flag", b, `FLAG_FREE);
    repeat (2) @(posedge ref_clk);
  endtask : cmd
  task automatic cfg_acc(input logic [7:0] a, input logic w, input logic [31:0] v);
    @(posedge ref_clk);
    cfg_req <= '{addr: a, wdata: v, we: w, re: !w};
    @(posedge ref_clk);
    cfg_req <= '0;
    @(posedge ref_clk);
  endtask : cfg_acc
  task automatic defaults;
    chk("clock_mode", board_cfg_r.clock_mode, 4'h0);
    chk("rate", board_cfg_r.rate, 8'haa);
    chk("law", board_cfg_r.law_mu, 1'b0);
    chk("opts", {board_cfg_r.opt_no_tei, board_cfg_r.opt_tei_split, board_cfg_r.opt_no_num_check}, 3'h0);
    chk("proto", board_cfg_r.proto, 32'h55555555);
  endtask : defaults
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    defaults();
    u_host.rd(13'h0100, b);
    chk("unmapped", b, 8'h00);
    cmd("IN");
    u_host.reply(rep);
    chk("ia", rep == "IA", 1'b1);
    chk("comms", board_cfg_r.comms_en, 1'b1);
    cmd("SC31");
    chk("clk", {board_cfg_r.clock_mode, board_cfg_r.clock_sub}, 8'h31);
    cmd("SB0122");
    chk("rate", board_cfg_r.rate, 8'ha4);
    cmd("SEM");
    chk("mu", board_cfg_r.law_mu, 1'b1);
    cmd("SEA");
    chk("a", board_cfg_r.law_mu, 1'b0);
    cmd("SS101");
    chk("opts", {board_cfg_r.opt_no_tei, board_cfg_r.opt_tei_split, board_cfg_r.opt_no_num_check}, 3'h5);
    cmd("SS010");
    chk("opts", {board_cfg_r.opt_no_tei, board_cfg_r.opt_tei_split, board_cfg_r.opt_no_num_check}, 3'h2);
    cmd("STNTU*NNNNNNNNNNNN");
    cmd("STNN");
    chk("ptype", board_cfg_r.ptype, 32'h55555509);
    cmd("SLP3");
    chk("proto", board_cfg_r.proto, 32'h55555555);
    cmd("STED");
    chk("term", {board_cfg_r.term_h100, board_cfg_r.term_legacy}, 2'h2);
    cmd("SFNF*NNNNNNNNNNNNN");
    chk("feed", board_cfg_r.feed_one, 16'hfff9);
    cmd("SX3A5");
    chk("slot", {board_cfg_r.base_stream, board_cfg_r.base_slot}, 12'h3a5);
    cmd("SL23P3333333333333");
    chk("proto", board_cfg_r.proto, 32'h55555564);
    cmd("SD0112345");
    cmd("SD02987");
    num_sel <= 5'h01;
    repeat (3) @(posedge ref_clk);
    chk("num", {num_out_r.digits[4:0], num_out_r.len, num_out_r.calling}, 25'h0a8642a);
    num_sel <= 5'h02;
    repeat (3) @(posedge ref_clk);
    chk("num", {num_out_r.digits[2:0], num_out_r.len, num_out_r.calling}, 17'h0f127);
    cmd("SD214");
    num_sel <= 5'h15;
    repeat (3) @(posedge ref_clk);
    chk("num", {num_out_r.digits[0], num_out_r.len, num_out_r.calling}, 9'h082);
    cfg_acc(`CFG_BAR2_OFF, 1'b1, 32'hffffffff);
    cfg_acc(`CFG_BAR2_OFF, 1'b0, 32'h0);
    chk("bar", cfg_rdata_r, `BAR2_SIZE_MASK);
    cfg_acc(`CFG_INT_OFF, 1'b1, 32'h5a);
    cfg_acc(`CFG_INT_OFF, 1'b0, 32'h0);
    chk("intline", cfg_rdata_r[7:0], 8'h5a);
    cfg_acc(`CFG_ID_OFF, 1'b0, 32'h0);
    chk("ident", cfg_rdata_r, 32'h00011234);
    cmd("RA");
    u_host.reply(rep);
    chk("ra", rep == "RA", 1'b1);
    chk("comms", board_cfg_r.comms_en, 1'b0);
    defaults();
    four_port <= 1'b1;
    repeat (5) @(posedge ref_clk);
    cmd("SFNF**NNNF");
    chk("feeds", {board_cfg_r.feed_one[3:0], board_cfg_r.feed_two[3:0]}, 8'h17);
    close_out();
  end
  // Whole sequence needs well under a thousand cycles; this leaves a wide margin
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
endmodule : cmd_parser_tb_top
`default_nettype wire
